// [design/bfs_supervisor.sv]
`default_nettype none
module bfs_supervisor #(
	parameter int unsigned NCH        = 4,
	parameter int unsigned GND_FILT   = bfs_pkg::GND_FILT_CYC,
	parameter int unsigned TEST_CUR   = bfs_pkg::TEST_CUR_CYC,
	parameter int unsigned I2C_TMO    = bfs_pkg::I2C_TMO_CYC,
	parameter int unsigned RECOVERY   = bfs_pkg::RECOVERY_CYC,
	parameter int unsigned FB_UV_TIME = bfs_pkg::FB_UV_CYC
) (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	// Device control pins
	input  wire logic                     i_enable,
	input  wire logic                     i_bright_nz,
	// Initialization results
	input  wire logic                     i_init_done,
	input  wire logic                     i_crc_fail,
	input  wire logic [2:0]               i_string_cfg,
	input  wire logic                     i_string_res_bad,
	input  wire logic                     i_mode_res_bad,
	input  wire logic                     i_mode_phase_shift,
	input  wire logic                     i_mode_addr_alt,
	input  wire logic                     i_freq_res_bad,
	input  wire logic [1:0]               i_bst_fsel,
	input  wire logic [1:0]               i_pwm_fsel,
	input  wire logic [NCH-1:0]           i_used_mask,
	input  wire logic [NCH-1:0]           i_unused_grounded,
	// Analog comparators
	input  wire logic [NCH-1:0]           i_below_gnd,
	input  wire logic [NCH-1:0]           i_below_headroom,
	input  wire logic                     i_vin_uv,
	input  wire logic                     i_vin_ov,
	input  wire logic                     i_vdd_low,
	input  wire logic                     i_vin_oc,
	input  wire logic                     i_cp_abnormal,
	input  wire logic                     i_cp_parts_missing,
	input  wire logic                     i_ovp_low,
	input  wire logic                     i_ovp_high,
	input  wire logic                     i_fb_uv,
	// Boost sync
	input  wire logic                     i_sync_valid,
	input  wire logic                     i_boost_sync_input,
	// I2C framing status
	input  wire logic                     i_i2c_busy,
	// Host clearing of summary flags
	input  wire logic                     i_int_clear,
	// Status
	output logic [bfs_pkg::NFLAGS-1:0]    o_flags,
	output logic [NCH-1:0]                o_per_channel_fault_flag,
	output logic                          o_int_n,
	output logic [2:0]                    o_state,
	// Actuators
	output logic                          o_boost_en,
	output logic                          o_boost_switch_en,
	output logic                          o_pl_switch_en,
	output logic [NCH-1:0]                o_led_en,
	output logic [NCH-1:0]                o_test_cur,
	output logic                          o_cp_en,
	output logic                          o_i2c_reset,
	// Settings in force
	output logic [2:0]                    o_string_cfg,
	output logic [NCH-1:0]                o_used_mask,
	output logic                          o_phase_shift,
	output logic [6:0]                    o_i2c_addr,
	output logic [1:0]                    o_bst_fsel,
	output logic [1:0]                    o_pwm_fsel,
	output logic                          o_use_int_clk,
	output logic                          o_spread_spectrum
);
	localparam int unsigned NF = bfs_pkg::NFLAGS;
	localparam int unsigned TW = $clog2(I2C_TMO + 1);
	initial
	begin
		if (NCH != 4 || RECOVERY < 1 || FB_UV_TIME < 1 || I2C_TMO < 1 ||
			RECOVERY >= I2C_TMO || FB_UV_TIME >= I2C_TMO)
			$error("bfs_supervisor: unsupported parameters");
	end

	// Asynchronous pin-side inputs, all but i_bright_nz, get two stages each
	localparam int unsigned NS = 2 * NCH + 14;
	logic [NS-1:0] raw_in;
	logic [NS-1:0] meta_q;
	logic [NS-1:0] sync_q;
	assign raw_in = {i_below_gnd, i_below_headroom, i_vin_uv, i_vin_ov, i_vdd_low, i_vin_oc,
		i_cp_abnormal, i_cp_parts_missing, i_ovp_low, i_ovp_high, i_fb_uv,
		i_sync_valid, i_boost_sync_input, i_enable, i_i2c_busy, i_int_clear};
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end
	logic [NCH-1:0] s_bgnd;
	logic [NCH-1:0] s_bhead;
	logic s_vin_uv, s_vin_ov, s_vdd_low, s_vin_oc, s_cp_abn, s_cp_miss, s_ovpl, s_ovph;
	logic s_fb_uv, s_sync_ok, s_sync_lvl, s_en, s_i2c_busy, s_clr;
	assign {s_bgnd, s_bhead, s_vin_uv, s_vin_ov, s_vdd_low, s_vin_oc, s_cp_abn, s_cp_miss,
		s_ovpl, s_ovph, s_fb_uv, s_sync_ok, s_sync_lvl, s_en, s_i2c_busy, s_clr} = sync_q;

	typedef struct packed {
		bfs_pkg::bfs_state_e st;
		logic [TW-1:0]       tmr;
		logic [TW-1:0]       fb_cnt;
		logic [TW-1:0]       i2c_cnt;
		logic [NF-1:0]       flags;
		logic [NCH-1:0]      chan_flag;
		logic                sync_seen;
		logic                clr_prev;
		logic                int_n;
		logic                i2c_rst;
		logic [2:0]          str_cfg;
		logic [NCH-1:0]      used;
		logic                phase;
		logic [6:0]          addr;
		logic [1:0]          bfs;
		logic [1:0]          pfs;
	} bfs_sup_s;
	bfs_sup_s s_q;
	bfs_sup_s s_d;

	logic [NCH-1:0] gnd_fault;
	logic [NCH-1:0] gnd_off;
	logic           gnd_arm;
	assign gnd_arm = (s_q.st == bfs_pkg::BFS_ST_RUN);
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_chan
			bfs_gnd_chan #(
				.FILT_CYC (GND_FILT),
				.TEST_CYC (TEST_CUR)
			) u_gnd (
				.i_clk            (i_clk),
				.i_rst_n          (i_rst_n),
				.i_arm            (gnd_arm & s_q.used[g]),
				.i_below_gnd      (s_bgnd[g]),
				.i_below_headroom (s_bhead[g]),
				.o_chan_off       (gnd_off[g]),
				.o_test_cur       (),
				.o_fault          (gnd_fault[g])
			);
		end
	endgenerate

	logic [NCH-1:0] test_cur_q;
	logic [NCH-1:0] led_en_q;
	logic           boost_en_q;
	logic           bsw_q;
	logic           pl_q;
	logic           cp_en_q;
	logic           int_clk_q;
	logic           ss_q;

	always_comb
	begin
		logic run;
		logic recover_evt;
		logic standby_hold;
		run = 1'b0;
		recover_evt = 1'b0;
		standby_hold = 1'b0;
		s_d = s_q;
		s_d.i2c_rst = 1'b0;
		s_d.clr_prev = s_clr;
		run = (s_q.st == bfs_pkg::BFS_ST_RUN);
		standby_hold = s_vin_uv | s_vin_ov | s_vdd_low | !s_en;
		// Host clear on rising edge; set below overrides
		if (s_clr && !s_q.clr_prev)
			s_d.flags = s_q.flags & ~bfs_pkg::CLEARABLE;
		if (s_vin_uv)
			s_d.flags[bfs_pkg::F_VIN_UV] = 1'b1;
		if (s_vin_ov)
			s_d.flags[bfs_pkg::F_VIN_OV] = 1'b1;
		if (s_vdd_low)
			s_d.flags[bfs_pkg::F_VDD_LOW] = 1'b1;
		if (run && s_vin_oc)
		begin
			s_d.flags[bfs_pkg::F_VIN_OC] = 1'b1;
			recover_evt = 1'b1;
		end
		if (run && s_cp_abn)
		begin
			s_d.flags[bfs_pkg::F_CP_LVL] = 1'b1;
			recover_evt = 1'b1;
		end
		if (s_cp_miss)
		begin
			s_d.flags[bfs_pkg::F_CP_PARTS] = 1'b1;
			s_d.flags[bfs_pkg::F_CP_LVL] = 1'b1;
		end
		// Sync loss only counts after a valid clock was seen
		if (s_q.st == bfs_pkg::BFS_ST_INIT || !s_en)
			s_d.sync_seen = 1'b0;
		else if (s_sync_ok)
			s_d.sync_seen = 1'b1;
		if (s_q.sync_seen && !s_sync_ok)
			s_d.flags[bfs_pkg::F_SYNC] = 1'b1;
		if (run && s_ovpl)
			s_d.flags[bfs_pkg::F_OVP_LOW] = 1'b1;
		if (run && s_ovph)
		begin
			s_d.flags[bfs_pkg::F_OVP_HIGH] = 1'b1;
			recover_evt = 1'b1;
		end
		if (!run || !s_fb_uv)
			s_d.fb_cnt = '0;
		else if (s_q.fb_cnt == TW'(FB_UV_TIME - 1))
		begin
			s_d.fb_cnt = '0;
			s_d.flags[bfs_pkg::F_BST_OC] = 1'b1;
			recover_evt = 1'b1;
		end
		else
			s_d.fb_cnt = s_q.fb_cnt + TW'(1);
		if (|gnd_fault)
		begin
			s_d.flags[bfs_pkg::F_SUMMARY] = 1'b1;
			s_d.flags[bfs_pkg::F_GND_DET] = 1'b1;
			s_d.chan_flag = s_q.chan_flag | gnd_fault;
			recover_evt = 1'b1;
		end
		// I2C timeout watchdog
		if (!s_i2c_busy)
			s_d.i2c_cnt = '0;
		else if (s_q.i2c_cnt == TW'(I2C_TMO - 1))
		begin
			s_d.i2c_cnt = '0;
			s_d.i2c_rst = 1'b1;
			s_d.flags[bfs_pkg::F_I2C_ERR] = 1'b1;
		end
		else
			s_d.i2c_cnt = s_q.i2c_cnt + TW'(1);
		unique case (s_q.st)
			bfs_pkg::BFS_ST_INIT:
				if (i_init_done)
				begin
					s_d.st = bfs_pkg::BFS_ST_STANDBY;
					s_d.str_cfg = i_string_res_bad ? bfs_pkg::DEF_STRING_CFG : i_string_cfg;
					s_d.used = i_string_res_bad ? bfs_pkg::DEF_USED_MASK : i_used_mask;
					s_d.phase = i_mode_res_bad ? bfs_pkg::DEF_PHASE_SHIFT : i_mode_phase_shift;
					s_d.addr = (i_mode_res_bad || !i_mode_addr_alt) ? bfs_pkg::DEF_I2C_ADDR
						: bfs_pkg::DEF_I2C_ADDR + 7'h01;
					s_d.bfs = i_freq_res_bad ? bfs_pkg::DEF_BST_FSEL : i_bst_fsel;
					s_d.pfs = i_freq_res_bad ? bfs_pkg::DEF_PWM_FSEL : i_pwm_fsel;
					s_d.flags[bfs_pkg::F_STR_RES] = i_string_res_bad;
					s_d.flags[bfs_pkg::F_MODE_RES] = i_mode_res_bad;
					s_d.flags[bfs_pkg::F_FREQ_RES] = i_freq_res_bad;
					s_d.flags[bfs_pkg::F_CRC] = i_crc_fail;
					if (|(~i_used_mask & ~i_unused_grounded) && !i_string_res_bad)
						s_d.flags[bfs_pkg::F_INVSTR] = 1'b1;
				end
			bfs_pkg::BFS_ST_STANDBY:
				if (!standby_hold && i_bright_nz)
					s_d.st = bfs_pkg::BFS_ST_RUN;
			bfs_pkg::BFS_ST_RUN:
				if (recover_evt)
				begin
					s_d.st = bfs_pkg::BFS_ST_RECOVER;
					s_d.tmr = '0;
				end
				else if (standby_hold)
					s_d.st = bfs_pkg::BFS_ST_STANDBY;
			bfs_pkg::BFS_ST_RECOVER:
				if (s_q.tmr == TW'(RECOVERY - 1))
					s_d.st = bfs_pkg::BFS_ST_WAIT_CLEAR;
				else
					s_d.tmr = s_q.tmr + TW'(1);
			bfs_pkg::BFS_ST_WAIT_CLEAR:
				// Overvoltage high waits for the output to fall
				if (!s_ovph && s_en && i_bright_nz)
					s_d.st = bfs_pkg::BFS_ST_STANDBY;
			default:
				s_d.st = bfs_pkg::BFS_ST_INIT;
		endcase
		s_d.int_n = !(|(s_d.flags & bfs_pkg::IRQ_MASK));
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			s_q <= '0;
			s_q.st <= bfs_pkg::BFS_ST_INIT;
			s_q.int_n <= 1'b1;
			test_cur_q <= '0;
			led_en_q <= '0;
			boost_en_q <= 1'b0;
			bsw_q <= 1'b0;
			pl_q <= 1'b0;
			cp_en_q <= 1'b0;
			int_clk_q <= 1'b0;
			ss_q <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
			test_cur_q <= gnd_off;
			led_en_q <= (s_d.st == bfs_pkg::BFS_ST_RUN) ? (s_d.used & ~gnd_off) : '0;
			boost_en_q <= (s_d.st == bfs_pkg::BFS_ST_RUN);
			bsw_q <= (s_d.st == bfs_pkg::BFS_ST_RUN) && !s_ovpl;
			pl_q <= (s_d.st == bfs_pkg::BFS_ST_RUN);
			cp_en_q <= (s_d.st != bfs_pkg::BFS_ST_INIT) && !s_d.flags[bfs_pkg::F_CP_PARTS];
			int_clk_q <= s_d.flags[bfs_pkg::F_SYNC] | !s_d.sync_seen;
			ss_q <= s_d.flags[bfs_pkg::F_SYNC] & s_sync_lvl;
		end
	end

	assign o_flags                  = s_q.flags;
	assign o_per_channel_fault_flag = s_q.chan_flag;
	assign o_int_n                  = s_q.int_n;
	assign o_state                  = s_q.st;
	assign o_boost_en               = boost_en_q;
	assign o_boost_switch_en        = bsw_q;
	assign o_pl_switch_en           = pl_q;
	assign o_led_en                 = led_en_q;
	assign o_test_cur               = test_cur_q;
	assign o_cp_en                  = cp_en_q;
	assign o_i2c_reset              = s_q.i2c_rst;
	assign o_string_cfg             = s_q.str_cfg;
	assign o_used_mask              = s_q.used;
	assign o_phase_shift            = s_q.phase;
	assign o_i2c_addr               = s_q.addr;
	assign o_bst_fsel               = s_q.bfs;
	assign o_pwm_fsel               = s_q.pfs;
	assign o_use_int_clk            = int_clk_q;
	assign o_spread_spectrum        = ss_q;
endmodule : bfs_supervisor
`default_nettype wire

// [design/bfs_pkg.sv]
// Notes on behaviour
// - Channel below ground-short threshold 20 ms: switch off, inject test current 300 us.
// - After test interval, declare ground short only if channel still below headroom.
// - Ground short disables boost, LEDs, power-line switch, then enters fault recovery.
// - Ground short sets summary, detail and per-channel flags; summary cleared by host.
// - Init: unused outputs not grounded set invalid-string flag and interrupt; keep running.
// - String configuration sampled only at initialization, held afterwards.
// - I2C open 500 ms without STOP: reset I2C logic, set error flag, interrupt.
// - Input undervoltage: flag, interrupt, standby, restart when input recovers.
// - Input overvoltage: flag, interrupt, standby, restart when input falls back.
// - Internal supply low: flag, interrupt, no recovery, restart when supply returns.
// - Input overcurrent or charge pump level: flag, interrupt, recovery, retry 100 ms.
// - Charge pump parts missing: flags, interrupt, pump off, keep operating.
// - Valid sync lost: flag, interrupt, internal frequency, spread spectrum per held level.
// - Config load check failure: flag and interrupt, keep operating normally.
// - Boost overvoltage low: flag without interrupt, suspend switching, stay normal.
// - Boost overvoltage high: flag, interrupt, recovery, wait for output to fall.
// - Feedback undervoltage 110 ms: overcurrent flag, interrupt, recovery, retry 100 ms.
// - String resistor invalid: flag without interrupt, default four channels 200 mA.
// - Mode resistor invalid: flag without interrupt, phase-shift dimming, address 0x3A.
// - Frequency resistor invalid: flag without interrupt, 400 kHz boost, 305 Hz dimming.
// - Recovery keeps drivers, boost, switch off 100 ms; restart if enabled and bright.
`default_nettype none
package bfs_pkg;
	localparam int unsigned CLK_HZ          = 200_000_000;
	localparam int unsigned GND_FILT_MS     = 20;
	localparam int unsigned TEST_CUR_US     = 300;
	localparam int unsigned I2C_TMO_MS      = 500;
	localparam int unsigned RECOVERY_MS     = 100;
	localparam int unsigned FB_UV_MS        = 110;
	localparam int unsigned GND_FILT_CYC    = GND_FILT_MS * (CLK_HZ / 1000);
	localparam int unsigned TEST_CUR_CYC    = TEST_CUR_US * (CLK_HZ / 1_000_000);
	localparam int unsigned I2C_TMO_CYC     = I2C_TMO_MS * (CLK_HZ / 1000);
	localparam int unsigned RECOVERY_CYC    = RECOVERY_MS * (CLK_HZ / 1000);
	localparam int unsigned FB_UV_CYC       = FB_UV_MS * (CLK_HZ / 1000);
	localparam logic [6:0]  DEF_I2C_ADDR    = 7'h3A;
	localparam logic [2:0]  DEF_STRING_CFG  = 3'h0;
	localparam logic [3:0]  DEF_USED_MASK   = 4'hF;
	localparam logic [1:0]  DEF_BST_FSEL    = 2'h0;
	localparam logic [1:0]  DEF_PWM_FSEL    = 2'h0;
	localparam logic        DEF_PHASE_SHIFT = 1'b1;
	// Fault word bit positions
	localparam int unsigned F_VIN_UV   = 0;
	localparam int unsigned F_VIN_OV   = 1;
	localparam int unsigned F_VDD_LOW  = 2;
	localparam int unsigned F_VIN_OC   = 3;
	localparam int unsigned F_CP_LVL   = 4;
	localparam int unsigned F_CP_PARTS = 5;
	localparam int unsigned F_SYNC     = 6;
	localparam int unsigned F_CRC      = 7;
	localparam int unsigned F_OVP_LOW  = 8;
	localparam int unsigned F_OVP_HIGH = 9;
	localparam int unsigned F_BST_OC   = 10;
	localparam int unsigned F_STR_RES  = 11;
	localparam int unsigned F_MODE_RES = 12;
	localparam int unsigned F_FREQ_RES = 13;
	localparam int unsigned F_SUMMARY  = 14;
	localparam int unsigned F_GND_DET  = 15;
	localparam int unsigned F_INVSTR   = 16;
	localparam int unsigned F_I2C_ERR  = 17;
	localparam int unsigned NFLAGS     = 18;
	// Resistor detection flags never interrupt
	localparam logic [NFLAGS-1:0] IRQ_MASK  = 18'h346FF;
	localparam logic [NFLAGS-1:0] CLEARABLE = 18'h346FF;
	typedef enum logic [2:0] {
		BFS_ST_INIT,
		BFS_ST_STANDBY,
		BFS_ST_RUN,
		BFS_ST_RECOVER,
		BFS_ST_WAIT_CLEAR
	} bfs_state_e;
endpackage : bfs_pkg
`default_nettype wire

// [design/bfs_gnd_chan.sv]
`default_nettype none
module bfs_gnd_chan #(
	parameter int unsigned FILT_CYC = bfs_pkg::GND_FILT_CYC,
	parameter int unsigned TEST_CYC = bfs_pkg::TEST_CUR_CYC
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Control
	input  wire logic i_arm,
	input  wire logic i_below_gnd,
	input  wire logic i_below_headroom,
	// Result
	output logic      o_chan_off,
	output logic      o_test_cur,
	output logic      o_fault
);
	localparam int unsigned CW = $clog2(FILT_CYC + 1);
	initial
	begin
		if (FILT_CYC < 1 || TEST_CYC < 1 || TEST_CYC > FILT_CYC)
			$error("bfs_gnd_chan: bad timing parameters");
	end
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          testing;
		logic          fault;
	} bfs_gnd_s;
	bfs_gnd_s s_q;
	bfs_gnd_s s_d;
	always_comb
	begin
		s_d = s_q;
		s_d.fault = 1'b0;
		if (!i_arm)
		begin
			s_d.cnt = '0;
			s_d.testing = 1'b0;
		end
		else if (!s_q.testing)
		begin
			if (!i_below_gnd)
				s_d.cnt = '0;
			else if (s_q.cnt == CW'(FILT_CYC - 1))
			begin
				s_d.cnt = '0;
				s_d.testing = 1'b1;
			end
			else
				s_d.cnt = s_q.cnt + CW'(1);
		end
		else if (s_q.cnt == CW'(TEST_CYC - 1))
		begin
			s_d.cnt = '0;
			s_d.testing = 1'b0;
			s_d.fault = i_below_headroom;
		end
		else
			s_d.cnt = s_q.cnt + CW'(1);
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign o_chan_off = s_q.testing;
	assign o_test_cur = s_q.testing;
	assign o_fault    = s_q.fault;
endmodule : bfs_gnd_chan
`default_nettype wire

// [testbench/bfs_host_model.sv]
`default_nettype none
module bfs_host_model (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	// Interrupt and clearing
	input  wire logic i_int_n,
	input  wire logic i_auto,
	output logic      o_int_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	// Status read itself not modelled, only the time it takes
	logic [5:0] cnt_q;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_q       <= 6'h00;
			o_int_clear <= 1'b0;
		end
		else
		begin
			cnt_q       <= (cnt_q == 6'h00) ? {5'h00, i_auto & ~i_int_n} : cnt_q + 6'h01;
			o_int_clear <= (cnt_q >= 6'h28) && (cnt_q < 6'h2C);
		end
	end
endmodule : bfs_host_model
`default_nettype wire

// [testbench/bfs_supervisor_monitor.sv]
`default_nettype none
module bfs_supervisor_monitor #(
	parameter int unsigned NCH      = 4,
	parameter int unsigned RECOVERY = 20,
	parameter int unsigned I2C_TMO  = 100
) (
	// Clock and reset
	input wire logic                         i_clk,
	input wire logic                         i_rst_n,
	// Watched inputs
	input wire logic                         i_vin_oc,
	input wire logic                         i_ovp_low,
	input wire logic                         i_i2c_busy,
	// Watched outputs
	input wire logic [bfs_pkg::NFLAGS-1:0]   o_flags,
	input wire logic [NCH-1:0]               o_per_channel_fault_flag,
	input wire logic                         o_int_n,
	input wire logic [2:0]                   o_state,
	input wire logic                         o_boost_en,
	input wire logic                         o_boost_switch_en,
	input wire logic                         o_pl_switch_en,
	input wire logic [NCH-1:0]               o_led_en,
	input wire logic [NCH-1:0]               o_test_cur,
	input wire logic                         o_i2c_reset,
	input wire logic [2:0]                   o_string_cfg,
	input wire logic [NCH-1:0]               o_used_mask
);
	typedef struct packed {
		logic [15:0] rec;
		logic [15:0] busy;
	} bfs_mon_s;
	bfs_mon_s m_q;
	bfs_mon_s m_d;
	always_comb
	begin
		m_d.rec  = (o_state == 3'h3) ? m_q.rec + 16'h0001 : 16'h0000;
		m_d.busy = i_i2c_busy ? m_q.busy + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			m_q <= '0;
		else
			m_q <= m_d;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	sequence s_oc_in_run;
		(i_vin_oc && o_state == 3'h2) [*3];
	endsequence
	sequence s_test_pulse;
		o_test_cur[0] [*7] ##[1:2] !o_test_cur[0];
	endsequence
	chk_oc_flag_set: assert property (s_oc_in_run |-> ##[0:3] o_flags[3])
		else $error("overcurrent flag not set");
	chk_irq_low: assert property ((|(o_flags & bfs_pkg::IRQ_MASK)) [*2] |-> !o_int_n)
		else $error("interrupt not asserted");
	chk_irq_high: assert property (((o_flags & bfs_pkg::IRQ_MASK) == '0) [*2] |-> o_int_n)
		else $error("interrupt without flag");
	chk_detail_sticky: assert property (1 |=> ((~o_flags & $past(o_flags)) & 18'h0B800) == '0
		&& (~o_per_channel_fault_flag & $past(o_per_channel_fault_flag)) == '0)
		else $error("detail flag cleared");
	chk_recover_off: assert property ((o_state == 3'h3) [*2] |-> !o_boost_en
		&& !o_pl_switch_en && o_led_en == '0)
		else $error("output on in recovery");
	chk_recover_min: assert property ($fell(o_state == 3'h3) |-> m_q.rec >= RECOVERY - 2)
		else $error("recovery too short");
	chk_recover_max: assert property (o_state == 3'h3 |-> m_q.rec <= RECOVERY + 2)
		else $error("recovery too long");
	chk_test_pulse: assert property ($rose(o_test_cur[0]) |-> s_test_pulse)
		else $error("test current length wrong");
	chk_test_led_off: assert property (o_test_cur != '0 |-> (o_test_cur & o_led_en) == '0)
		else $error("channel on under test");
	chk_ovp_low_run: assert property ((i_ovp_low && o_state == 3'h2) [*4] |->
		!o_boost_switch_en && o_state == 3'h2)
		else $error("overvoltage low handling wrong");
	chk_i2c_timeout: assert property (o_i2c_reset |-> m_q.busy >= I2C_TMO
		##1 !o_i2c_reset ##[0:2] o_flags[17])
		else $error("bus timeout wrong");
	chk_cfg_hold: assert property ((o_state != 3'h0) [*2] |=>
		$stable(o_string_cfg) && $stable(o_used_mask))
		else $error("settings changed after init");
endmodule : bfs_supervisor_monitor
bind bfs_supervisor bfs_supervisor_monitor #(.NCH(NCH), .RECOVERY(RECOVERY), .I2C_TMO(I2C_TMO))
	u_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_vin_oc(i_vin_oc), .i_ovp_low(i_ovp_low),
	.i_i2c_busy(i_i2c_busy), .o_flags(o_flags), .o_per_channel_fault_flag(o_per_channel_fault_flag),
	.o_int_n(o_int_n), .o_state(o_state), .o_boost_en(o_boost_en),
	.o_boost_switch_en(o_boost_switch_en), .o_pl_switch_en(o_pl_switch_en), .o_led_en(o_led_en),
	.o_test_cur(o_test_cur), .o_i2c_reset(o_i2c_reset), .o_string_cfg(o_string_cfg),
	.o_used_mask(o_used_mask));
`default_nettype wire

// [testbench/bfs_supervisor_tb.sv]
`default_nettype none
module bfs_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_rst_n, en, bright, init_done, crc, sbad, mbad, mps, malt, fbad;
	logic        sv, ssync, busy, auto, clr, o_int_n, o_boost_en, o_bsw, o_pl_switch_en;
	logic        o_cp_en, o_i2c_reset, o_phase_shift, o_int_clk, o_ss;
	logic [2:0]  scfg, o_state, o_string_cfg;
	logic [1:0]  bfs, pfs, o_bst_fsel, o_pwm_fsel;
	logic [3:0]  used, ugnd, bg, bh, pcf, o_led_en, o_test_cur, o_used_mask;
	logic [8:0]  cmp;
	logic [17:0] o_flags;
	logic [6:0]  o_i2c_addr;
	int          mismatches, checked, n, k;
	int          rec_in[3] = '{3, 4, 7};
	int          rec_bit[3] = '{3, 4, 9};
	bfs_supervisor #(.GND_FILT(40), .TEST_CUR(8), .I2C_TMO(100), .RECOVERY(20), .FB_UV_TIME(30))
	u_dut (
		.i_clk, .i_rst_n, .i_enable(en), .i_bright_nz(bright), .i_init_done(init_done),
		.i_crc_fail(crc), .i_string_cfg(scfg), .i_string_res_bad(sbad), .i_mode_res_bad(mbad),
		.i_mode_phase_shift(mps), .i_mode_addr_alt(malt), .i_freq_res_bad(fbad),
		.i_bst_fsel(bfs), .i_pwm_fsel(pfs), .i_used_mask(used), .i_unused_grounded(ugnd),
		.i_below_gnd(bg), .i_below_headroom(bh), .i_vin_uv(cmp[0]), .i_vin_ov(cmp[1]),
		.i_vdd_low(cmp[2]), .i_vin_oc(cmp[3]), .i_cp_abnormal(cmp[4]),
		.i_cp_parts_missing(cmp[5]), .i_ovp_low(cmp[6]), .i_ovp_high(cmp[7]), .i_fb_uv(cmp[8]),
		.i_sync_valid(sv), .i_boost_sync_input(ssync), .i_i2c_busy(busy), .i_int_clear(clr),
		.o_flags, .o_per_channel_fault_flag(pcf), .o_int_n, .o_state, .o_boost_en,
		.o_boost_switch_en(o_bsw), .o_pl_switch_en, .o_led_en, .o_test_cur, .o_cp_en,
		.o_i2c_reset, .o_string_cfg, .o_used_mask, .o_phase_shift, .o_i2c_addr, .o_bst_fsel,
		.o_pwm_fsel, .o_use_int_clk(o_int_clk), .o_spread_spectrum(o_ss)
	);
	bfs_host_model u_host (.i_clk, .i_rst_n, .i_int_n(o_int_n), .i_auto(auto), .o_int_clear(clr));
	always #2.5 i_clk = ~i_clk;
	task automatic tick(input int c);
		repeat (c) @(posedge i_clk);
		#1;
	endtask : tick
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	task automatic chk_word(input logic [19:0] got, input logic [19:0] exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({19'h0, got}, {19'h0, exp});
	endtask : chk_bit
	// Bounded waits; running out ends the run
	task automatic wst(input logic [2:0] s, input int lim);
		n = 0;
		while (o_state !== s && n < lim)
		begin
			tick(1);
			n++;
		end
		chk_word({17'h0, o_state}, {17'h0, s});
		if (o_state !== s)
			wrap_up();
	endtask : wst
	task automatic wflag(input int w, input int lim);
		n = 0;
		while (((w < 4) ? o_test_cur[w] : o_i2c_reset) !== 1'b1 && n < lim)
		begin
			tick(1);
			n++;
		end
		if (n >= lim)
		begin
			mismatches++;
			wrap_up();
		end
	endtask : wflag
	initial
	begin
		{i_clk, i_rst_n, init_done, mps, sv, busy, bg, bh, cmp} = '0;
		{en, bright, auto, ssync, crc, sbad, mbad, malt, fbad} = '1;
		scfg = 3'h5;
		used = 4'h3;
		ugnd = 4'h4;
		bfs = 2'h2;
		pfs = 2'h1;
		tick(3);
		i_rst_n = 1'b1;
		tick(2);
		init_done = 1'b1;
		wst(3'h2, 50);
		tick(3);
		chk_word(o_flags & 18'h03880, 18'h03880);
		chk_word({o_string_cfg, o_used_mask, o_phase_shift, o_i2c_addr, o_bst_fsel, o_pwm_fsel},
			{3'h0, 4'hF, 1'b1, 7'h3A, 2'h0, 2'h0});
		chk_bit(o_int_n, 1'b0);
		tick(60);
		chk_word(o_flags, 18'h03800);
		chk_bit(o_int_n, 1'b1);
		i_rst_n = 1'b0;
		{crc, sbad, mbad, fbad} = '0;
		tick(3);
		i_rst_n = 1'b1;
		wst(3'h2, 50);
		tick(3);
		chk_word(o_flags, 18'h10000);
		chk_word({o_int_n, o_led_en}, 5'h03);
		chk_word({o_string_cfg, o_used_mask, o_phase_shift, o_i2c_addr, o_bst_fsel, o_pwm_fsel},
			{3'h5, 4'h3, 1'b0, 7'h3B, 2'h2, 2'h1});
		scfg = 3'h1;
		used = 4'hF;
		sbad = 1'b1;
		tick(60);
		chk_word({o_string_cfg, o_used_mask}, {3'h5, 4'h3});
		for (k = 0; k < 3; k++)
		begin
			cmp[rec_in[k]] = 1'b1;
			tick(4);
			cmp = '0;
			wst(3'h3, 10);
			tick(2);
			chk_word({o_flags[rec_bit[k]], o_int_n, o_boost_en, o_pl_switch_en, o_led_en}, 8'h80);
			wst(3'h2, 60);
			tick(60);
		end
		cmp[3] = 1'b1;
		tick(4);
		cmp = '0;
		en = 1'b0;
		tick(40);
		chk_word({o_boost_en, o_state}, 4'h4);
		en = 1'b1;
		wst(3'h2, 20);
		cmp[8] = 1'b1;
		tick(20);
		chk_bit(o_flags[10], 1'b0);
		tick(15);
		cmp[8] = 1'b0;
		wst(3'h3, 10);
		chk_bit(o_flags[10], 1'b1);
		wst(3'h2, 60);
		tick(60);
		bg[0] = 1'b1;
		wflag(0, 60);
		chk_bit(n >= 40, 1'b1);
		chk_bit(o_led_en[0], 1'b0);
		tick(12);
		chk_word({o_test_cur[0], o_state}, 4'h2);
		bg = 4'h2;
		bh = 4'h2;
		wflag(1, 60);
		wst(3'h3, 15);
		bg = 4'h0;
		bh = 4'h0;
		tick(2);
		chk_word({o_flags[15:14], pcf, o_boost_en, o_pl_switch_en, o_bsw}, 9'h190);
		wst(3'h2, 60);
		tick(60);
		chk_word({o_flags[15:14], pcf, o_int_n}, 7'h45);
		cmp[6] = 1'b1;
		tick(6);
		chk_word({o_flags[8], o_bsw, o_boost_en, o_int_n, o_state}, 7'h5A);
		cmp[6] = 1'b0;
		tick(4);
		chk_bit(o_bsw, 1'b1);
		for (k = 0; k < 3; k++)
		begin
			cmp[k] = 1'b1;
			tick(6);
			chk_word({o_flags[k], o_boost_en, o_state}, 5'h11);
			cmp[k] = 1'b0;
			wst(3'h2, 20);
		end
		cmp[5] = 1'b1;
		tick(6);
		chk_word({o_flags[5:4], o_cp_en, o_state}, 6'h32);
		sv = 1'b1;
		tick(6);
		chk_bit(o_int_clk, 1'b0);
		sv = 1'b0;
		tick(6);
		chk_word({o_flags[6], o_int_clk, o_ss}, 3'h7);
		// Host clearing off, so the error flag survives until it is looked at
		auto = 1'b0;
		busy = 1'b1;
		wflag(4, 130);
		chk_bit(n >= 100, 1'b1);
		tick(3);
		chk_bit(o_flags[17], 1'b1);
		busy = 1'b0;
		wrap_up();
	end
endmodule : bfs_supervisor_tb
`default_nettype wire
